// ==== testbench/sml_loader_tb_top.sv ====
// self-checking bench of the serial memory loader
`timescale 1ns/10ps
// ======================================
module sml_loader_tb_top;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, ce = 1;
    logic pready, pslverr, irq, scl, oe, pull;
    logic [15:0] mode_o;
    logic [31:0] gphy_o;
    logic [63:0] port_o;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, wv, q [$]; // expected reads in order
    wire sda = ~(oe | pull); // pulled-up line
    int n_errors = 0, samples_checked = 0;
    always #5 pclk = ~pclk;
    // random freeze cycles exercise the clock enable on both sides
    always @(posedge pclk)
        ce <= ($urandom() % 8) != 0;
    sml_loader sml_loader_i (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq), .serial_memory_clock_out(scl),
        .serial_memory_data_in(sda), .serial_memory_data_out(), .serial_memory_data_oe(oe),
        .switch_mode_config(mode_o), .global_phy_control(gphy_o), .port_phy_control(port_o));
    sml_mem_model sml_mem_model_i (.scl(scl), .sda(sda), .pull(pull));
    function automatic logic [15:0] w(int a); // memory word, low byte even
        return {sml_mem_model_i.mem[a + 1], sml_mem_model_i.mem[a]};
    endfunction
    task automatic check(string s, logic [31:0] v, logic [31:0] e);
        samples_checked++;
        n_errors += (v !== e);
        if (v !== e)
            $display("ERROR %s expected %h seen %h", s, e, v);
    endtask
    task automatic apb(logic wr, logic [11:0] a, logic [31:0] d = 0, logic [31:0] e = 0);
        if (!wr)
            q.push_back(e);
        {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
        @(posedge pclk) penable <= 1;
        @(posedge pclk iff pready === 1'b1) {psel, penable} <= 2'b00;
        @(posedge pclk);
    endtask
    task automatic ev(); // wait for an event, then clear all status
        @(posedge pclk iff irq === 1'b1);
        apb(1, 12'h008, 32'h7);
        check("irq", irq, 0);
    endtask
    task automatic finish_test(int extra);
        n_errors += extra;
        if (n_errors == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    always @(posedge pclk) // completed access against oldest note
    begin
        if (psel && penable && pready)
            check("pslverr", pslverr, paddr == 12'hffc);
        if (psel && penable && pready && !pwrite)
            check("prdata", prdata, q.pop_front());
    end
    // about two and a half times the cycles the two loads and both software accesses need
    initial #500000 finish_test(1);
    initial
    begin
        void'($urandom(72395));
        for (int k = 0; k < 512; k++)
            sml_mem_model_i.mem[k] = 8'($urandom());
        {sml_mem_model_i.mem[1], sml_mem_model_i.mem[0]} = 16'h5aa5;
        repeat (10) @(posedge pclk);
        presetn <= 1;
        apb(1, 12'h00c, 32'h7);
        apb(0, 12'h0dc, 0, 32'h9);
        ev();
        apb(0, 12'h0dc, 0, 32'h2);
        apb(0, 12'h010, 0, w(6));
        apb(0, 12'h014, 0, {w(24), w(22)});
        for (int n = 0; n < 4; n++)
            apb(0, 12'h020 + 12'(4 * n), 0, w(32 + 2 * n));
        check("mode out", mode_o, w(6));
        check("global phy out", gphy_o, {w(24), w(22)});
        check("port 0 out", port_o[15:0], w(32));
        check("port 3 out", port_o[63:48], w(38));
        apb(0, 12'hffc);
        wv = $urandom();
        apb(1, 12'h000, {wv[15:0], 16'h4003});
        ev();
        check("memory word", w(128), wv[15:0]);
        apb(1, 12'h000, 32'h0000_4001);
        ev();
        apb(0, 12'h004, 0, {16'h0000, wv[15:0]});
        // second reset over a wrong signature: load skipped, defaults kept
        {sml_mem_model_i.mem[1], sml_mem_model_i.mem[0]} = 16'ha55a;
        presetn <= 0;
        repeat (3) @(posedge pclk);
        presetn <= 1;
        apb(1, 12'h00c, 32'h7);
        apb(0, 12'h0dc, 0, 32'h9);
        ev();
        apb(0, 12'h0dc, 0, 32'h0);
        apb(0, 12'h010, 0, 32'h0);
        check("mode out", mode_o, 16'h0000);
        finish_test(0);
    end
endmodule // sml_loader_tb_top

// ==== testbench/sml_mem_model.sv ====
// two-wire serial memory model, 512x8, select strapped to 0
`timescale 1ns/10ps
// ======================================
module sml_mem_model (
    input wire logic scl,
    input wire logic sda,
    output logic pull
);
    logic [7:0] sh, mem [0:511]; // shift byte, array
    logic [8:0] ptr = 9'h000; // byte pointer
    int b = 9, st = 4, ack; // slot 8 = ack; st 0 sel 1 addr 2 wr 3 rd 4 idle
    initial pull = 1'b0;
    always @(negedge sda) // start: data falls under a high clock
        {b, st} = scl ? {32'd9, 32'd0} : {b, st};
    always @(posedge sda) // stop
        st = scl ? 4 : st;
    always @(posedge scl) // sample; a master no-ack ends a read
        if (b < 8)
            sh = {sh[6:0], sda};
        else if (st == 3 && sda)
            st = 4;
    always @(negedge scl) // drive only while the clock is low
    begin
        b = (b >= 8) ? 0 : b + 1;
        ack = (b == 8 && st < 3);
        pull = (b < 8 && st == 3) ? ~mem[ptr][7 - b] : 1'b0; // msb first
        if (b == 8 && st == 2)
            mem[ptr] = sh;
        if (b == 8 && st > 1 && st < 4)
            ptr = ptr + 9'h001; // low byte at even address
        if (b == 8 && st == 1)
            {st, ptr} = {32'd2, 1'b0, sh};
        if (b == 8 && st == 0)
            st = (sh[7:2] == 6'b101000) ? (sh[0] ? 3 : 1) : 4;
        pull = pull | (ack != 0 && st != 4);
    end
endmodule // sml_mem_model

// ==== verilog/sml_defs.svh ====
// named constants of the serial memory configuration loader
`ifndef SML_DEFS_SVH
`define SML_DEFS_SVH
// timing: core clock and serial memory clock periods in ns
`define SML_CLK_PERIOD_NS 10
`define SML_SCL_PERIOD_NS 160
`define SML_QTR_CYCLES ((`SML_SCL_PERIOD_NS / `SML_CLK_PERIOD_NS) / 4)
// device-select bytes, address inputs strapped to zero
`define SML_CTRL_WR 8'ha0
`define SML_CTRL_RD 8'ha1
// value that marks a programmed memory
`define SML_SIGNATURE 16'h5aa5
// word addresses (byte offset / 2)
`define SML_WORD_SIG 7'h00
`define SML_WORD_FIRST 7'h01
`define SML_WORD_MODE 7'h03
`define SML_WORD_GPHY_LO 7'h0b
`define SML_WORD_GPHY_HI 7'h0c
`define SML_WORD_PORT0 7'h10
`define SML_WORD_LAST 7'h13
`define SML_PORTS 4
`define SML_ACK_BIT 4'h8
// apb byte offsets
`define SML_OFF_SEQ_CMD 12'h000
`define SML_OFF_SEQ_DATA 12'h004
`define SML_OFF_IRQ_STATUS 12'h008
`define SML_OFF_IRQ_MASK 12'h00c
`define SML_OFF_MODE 12'h010
`define SML_OFF_GPHY 12'h014
`define SML_OFF_LOAD_STATUS 12'h0dc
`define SML_PORT_PAGE 8'h02
// command register fields
`define SML_CMD_START 0
`define SML_CMD_WRITE 1
// interrupt bits
`define SML_IRQ_LOAD 0
`define SML_IRQ_SEQ 1
`define SML_IRQ_NACK 2
`define SML_IRQ_W 3
// hardware defaults of the loaded registers
`define SML_RST_MODE 16'h0000
`define SML_RST_GPHY 32'h0000_0000
`endif

// ==== verilog/sml_engine_if.sv ====
// command link between the word sequencer and the two-wire engine
`timescale 1ns/10ps
interface sml_engine_if;
    import sml_pkg::*;
    logic cmd_valid; // one-cycle request, engine idle
    sml_cmd_t cmd;
    logic [7:0] wdata;
    logic send_nack; // read: answer with no-ack
    logic done; // one-cycle end of command
    logic ack_ok; // write: memory acknowledged
    logic [7:0] rdata;
    modport seq (output cmd_valid, cmd, wdata, send_nack, input done, ack_ok, rdata);
    modport eng (input cmd_valid, cmd, wdata, send_nack, output done, ack_ok, rdata);
endinterface

// ==== verilog/sml_loader.sv ====
// serial memory configuration loader: apb registers and word sequencer
//
// The implementer's own choices: the placing of the registers and register access over APB.
`timescale 1ns/10ps
`include "sml_defs.svh"
// ==========================================================
module sml_loader #(
    parameter int QTR = `SML_QTR_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    output logic serial_memory_clock_out,
    input wire logic serial_memory_data_in,
    output logic serial_memory_data_out,
    output logic serial_memory_data_oe,
    output logic [15:0] switch_mode_config,
    output logic [31:0] global_phy_control,
    output logic [`SML_PORTS*16-1:0] port_phy_control
);
    import sml_pkg::*;
    // ==========================================================
    // state
    typedef struct packed {
        sml_seq_st_t st;
        logic issued; // engine command outstanding
        logic is_auto; // current access belongs to the load
        logic loading; // load progress flag
        logic [6:0] word; // word address of the access
        logic wr; // software access direction
        logic [15:0] wdata;
        logic [15:0] data; // word being read
        logic [15:0] seq_data; // last software read
        logic sig_ok;
        logic nack_err;
        logic [`SML_IRQ_W-1:0] irq_status;
        logic [`SML_IRQ_W-1:0] irq_mask;
        logic [15:0] mode;
        logic [31:0] gphy;
        logic [`SML_PORTS-1:0][15:0] port;
        logic [31:0] prdata;
        logic armed; // read data latched for this transfer
    } sml_seq_state_t;
    // load starts straight out of reset
    localparam sml_seq_state_t SEQ_RESET = '{st: S_START, is_auto: 1'b1, loading: 1'b1,
        word: `SML_WORD_SIG, mode: `SML_RST_MODE, gphy: `SML_RST_GPHY, default: '0};
    sml_seq_state_t r;
    sml_seq_state_t next_r;
    sml_engine_if bus ();
    logic [`SML_IRQ_W-1:0] irq_set; // events this cycle
    logic [`SML_IRQ_W-1:0] irq_clr; // write-one-to-clear
    logic [31:0] rd_val;
    logic mapped;
    logic xfer; // apb access completes
    // ==========================================================
    // engine command for the current state
    always_comb
    begin
        bus.cmd = C_WRITE;
        bus.wdata = 8'h00;
        bus.send_nack = 1'b0;
        case (r.st)
            S_START, S_RESTART: bus.cmd = C_START;
            S_CTRLW: bus.wdata = `SML_CTRL_WR;
            S_ADDR: bus.wdata = {r.word, 1'b0};
            S_CTRLR: bus.wdata = `SML_CTRL_RD;
            S_RDLO: bus.cmd = C_READ;
            S_RDHI:
            begin
                bus.cmd = C_READ;
                bus.send_nack = 1'b1; // last byte of the word
            end
            S_WRLO: bus.wdata = r.wdata[7:0];
            S_WRHI: bus.wdata = r.wdata[15:8];
            S_STOP: bus.cmd = C_STOP;
            default: bus.cmd = C_WRITE;
        endcase
    end
    // only states that talk to the memory raise a request
    assign bus.cmd_valid = (r.st != S_IDLE) && (r.st != S_DONE) && !r.issued;
    assign xfer = psel && penable && pready;
    // ==========================================================
    // next state: sequencer, load bookkeeping, apb
    always_comb
    begin
        next_r = r;
        irq_set = '0;
        irq_clr = '0;
        rd_val = 32'h0000_0000;
        mapped = 1'b1;
        if (bus.cmd_valid)
            next_r.issued = 1'b1;
        if (bus.done)
            next_r.issued = 1'b0;
        if (bus.done && bus.cmd == C_WRITE && !bus.ack_ok)
            next_r.nack_err = 1'b1;
        // ------ word sequencer
        case (r.st)
            S_START: if (bus.done) next_r.st = S_CTRLW;
            S_RESTART: if (bus.done) next_r.st = S_CTRLR;
            S_CTRLW: if (bus.done) next_r.st = bus.ack_ok ? S_ADDR : S_STOP;
            S_ADDR:
            begin
                if (bus.done && !bus.ack_ok)
                    next_r.st = S_STOP;
                else if (bus.done)
                    next_r.st = r.wr ? S_WRLO : S_RESTART;
            end
            S_CTRLR: if (bus.done) next_r.st = bus.ack_ok ? S_RDLO : S_STOP;
            S_RDLO:
            begin
                if (bus.done)
                begin
                    next_r.data[7:0] = bus.rdata; // low byte at even address
                    next_r.st = S_RDHI;
                end
            end
            S_RDHI:
            begin
                if (bus.done)
                begin
                    next_r.data[15:8] = bus.rdata;
                    next_r.st = S_STOP;
                end
            end
            S_WRLO: if (bus.done) next_r.st = bus.ack_ok ? S_WRHI : S_STOP;
            S_WRHI: if (bus.done) next_r.st = S_STOP;
            S_STOP: if (bus.done) next_r.st = S_DONE;
            S_DONE:
            begin
                if (r.is_auto)
                begin
                    // store the word in its configuration register
                    if (!r.nack_err)
                    begin
                        if (r.word == `SML_WORD_MODE)
                            next_r.mode = r.data;
                        if (r.word == `SML_WORD_GPHY_LO)
                            next_r.gphy[15:0] = r.data;
                        if (r.word == `SML_WORD_GPHY_HI)
                            next_r.gphy[31:16] = r.data;
                        if (r.word >= `SML_WORD_PORT0 && r.word <= `SML_WORD_LAST)
                            next_r.port[2'(r.word - `SML_WORD_PORT0)] = r.data;
                    end
                    if (r.word == `SML_WORD_SIG)
                        next_r.sig_ok = !r.nack_err && r.data == `SML_SIGNATURE;
                    // a missing memory ends the load as an unknown signature would
                    if (r.nack_err || r.word == `SML_WORD_LAST ||
                        (r.word == `SML_WORD_SIG && r.data != `SML_SIGNATURE))
                    begin
                        next_r.loading = 1'b0;
                        next_r.is_auto = 1'b0;
                        next_r.st = S_IDLE;
                        irq_set[`SML_IRQ_LOAD] = 1'b1;
                        irq_set[`SML_IRQ_NACK] = r.nack_err;
                    end
                    else
                    begin
                        next_r.word = r.word + 7'h01;
                        next_r.nack_err = 1'b0;
                        next_r.st = S_START;
                    end
                end
                else
                begin
                    if (!r.wr)
                        next_r.seq_data = r.data;
                    next_r.st = S_IDLE;
                    irq_set[`SML_IRQ_SEQ] = 1'b1;
                    irq_set[`SML_IRQ_NACK] = r.nack_err;
                end
            end
            S_IDLE: next_r.issued = 1'b0;
            default: next_r.st = S_IDLE;
        endcase
        // ------ register read decode
        case (paddr)
            `SML_OFF_SEQ_CMD: rd_val = {r.wdata, 1'b0, r.word, 6'h00, r.wr, 1'b0};
            `SML_OFF_SEQ_DATA: rd_val = {16'h0000, r.seq_data};
            `SML_OFF_IRQ_STATUS: rd_val = {29'h0000_0000, r.irq_status};
            `SML_OFF_IRQ_MASK: rd_val = {29'h0000_0000, r.irq_mask};
            `SML_OFF_MODE: rd_val = {16'h0000, r.mode};
            `SML_OFF_GPHY: rd_val = r.gphy;
            `SML_OFF_LOAD_STATUS:
                rd_val = {28'h000_0000, r.loading, r.nack_err, r.sig_ok, r.st != S_IDLE};
            default:
            begin
                if (paddr[11:4] == `SML_PORT_PAGE)
                    rd_val = {16'h0000, r.port[paddr[3:2]]};
                else
                    mapped = 1'b0; // unmapped reads return zero
            end
        endcase
        // read data is captured one cycle ahead so the access needs no wait
        if (psel)
            next_r.prdata = rd_val;
        next_r.armed = psel && !xfer;
        // ------ register writes, taken at the completing edge
        if (xfer && pwrite)
        begin
            case (paddr)
                `SML_OFF_SEQ_CMD:
                begin
                    // a start while busy is dropped; software must poll first
                    if (pwdata[`SML_CMD_START] && r.st == S_IDLE && !r.loading)
                    begin
                        next_r.word = pwdata[14:8];
                        next_r.wr = pwdata[`SML_CMD_WRITE];
                        next_r.wdata = pwdata[31:16];
                        next_r.is_auto = 1'b0;
                        next_r.nack_err = 1'b0;
                        next_r.st = S_START;
                    end
                end
                `SML_OFF_IRQ_STATUS: irq_clr = pwdata[`SML_IRQ_W-1:0];
                `SML_OFF_IRQ_MASK: next_r.irq_mask = pwdata[`SML_IRQ_W-1:0];
                `SML_OFF_MODE: next_r.mode = pwdata[15:0];
                `SML_OFF_GPHY: next_r.gphy = pwdata;
                default:
                begin
                    if (paddr[11:4] == `SML_PORT_PAGE)
                        next_r.port[paddr[3:2]] = pwdata[15:0];
                end
            endcase
        end
        // an event in the clearing cycle survives
        next_r.irq_status = (r.irq_status & ~irq_clr) | irq_set;
    end
    // ==========================================================
    // registers, frozen while ce is low
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            r <= SEQ_RESET;
        else if (ce)
            r <= next_r;
    end
    // ==========================================================
    // two-wire engine
    sml_wire_engine #(.QTR(QTR)) u_engine (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .bus(bus),
        .scl_out(serial_memory_clock_out),
        .sda_in(serial_memory_data_in),
        .sda_out(serial_memory_data_out),
        .sda_oe(serial_memory_data_oe)
    );
    // ==========================================================
    // outputs
    assign prdata = r.prdata;
    assign pready = ce && r.armed; // stretches the access while frozen
    assign pslverr = psel && penable && !mapped;
    assign irq = |(r.irq_status & r.irq_mask);
    assign switch_mode_config = r.mode;
    assign global_phy_control = r.gphy;
    assign port_phy_control = r.port;
    // ==========================================================
    // checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    a_select_zero: assert property (bus.cmd_valid && r.st == S_CTRLW
        |-> bus.wdata == `SML_CTRL_WR)
        else $error("device select not zero");
    a_word_addr: assert property (bus.cmd_valid && r.st == S_ADDR
        |-> bus.wdata == {r.word, 1'b0})
        else $error("byte address not twice the word address");
    a_sig_accept: assert property (ce && r.st == S_DONE && r.is_auto &&
        r.word == `SML_WORD_SIG && !r.nack_err && r.data == `SML_SIGNATURE
        |=> r.loading && r.st == S_START && r.word == `SML_WORD_FIRST)
        else $error("good signature did not start the load");
    a_sig_reject: assert property (ce && r.st == S_DONE && r.is_auto &&
        r.word == `SML_WORD_SIG && r.data != `SML_SIGNATURE
        |=> !r.loading && r.st == S_IDLE && $stable(r.gphy))
        else $error("bad signature did not end the load");
    a_load_hold: assert property ($fell(r.loading)
        |-> $past(r.st) == S_DONE && $past(r.is_auto))
        else $error("load flag dropped outside load end");
    a_load_step: assert property (ce && r.st == S_DONE && r.is_auto &&
        !r.nack_err && r.word != `SML_WORD_SIG && r.word != `SML_WORD_LAST
        |=> r.word == $past(r.word) + 7'h01 && r.st == S_START)
        else $error("load did not move to next word");
    a_gphy_load: assert property (ce && r.st == S_DONE && r.is_auto &&
        !r.nack_err && r.word == `SML_WORD_GPHY_HI
        |=> r.gphy[31:16] == $past(r.data))
        else $error("global phy upper half not loaded");
    a_port_load: assert property (ce && r.st == S_DONE && r.is_auto &&
        !r.nack_err && r.word == `SML_WORD_LAST
        |=> r.port[3] == $past(r.data) && !r.loading)
        else $error("last port word not loaded");
    a_status_read: assert property (ce && psel && !penable &&
        paddr == `SML_OFF_LOAD_STATUS |=> prdata[3] == $past(r.loading))
        else $error("load status bit wrong");
    a_seq_start: assert property (ce && xfer && pwrite && paddr == `SML_OFF_SEQ_CMD &&
        pwdata[`SML_CMD_START] && r.st == S_IDLE && !r.loading
        |=> r.st == S_START && !r.is_auto && bus.cmd_valid)
        else $error("software start not taken");
endmodule // sml_loader

// ==== verilog/sml_pkg.sv ====
// types shared by the loader and its two-wire engine
package sml_pkg;
    // engine byte-level commands
    typedef enum logic [1:0] {C_START = 2'b00, C_STOP = 2'b01, C_WRITE = 2'b10,
        C_READ = 2'b11} sml_cmd_t;
    // engine states
    typedef enum logic [1:0] {E_IDLE = 2'b00, E_START = 2'b01, E_STOP = 2'b10,
        E_BYTE = 2'b11} sml_eng_st_t;
    // word sequencer states
    typedef enum logic [3:0] {S_IDLE = 4'b0000, S_START = 4'b0001, S_CTRLW = 4'b0010,
        S_ADDR = 4'b0011, S_RESTART = 4'b0100, S_CTRLR = 4'b0101, S_RDLO = 4'b0110,
        S_RDHI = 4'b0111, S_WRLO = 4'b1000, S_WRHI = 4'b1001, S_STOP = 4'b1010,
        S_DONE = 4'b1011} sml_seq_st_t;
endpackage

// ==== verilog/sml_wire_engine.sv ====
// two-wire bit engine: start, stop, byte write and byte read
`timescale 1ns/10ps
`include "sml_defs.svh"
module sml_wire_engine #(
    parameter int QTR = `SML_QTR_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    sml_engine_if.eng bus,
    output logic scl_out,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe
);
    import sml_pkg::*;
    // ==========================================================
    // state
    typedef struct packed {
        sml_eng_st_t st;
        logic [7:0] qcnt; // cycles within a quarter bit
        logic [1:0] qtr; // quarter of the bit
        logic [3:0] bitn; // 0..7 data, 8 ack
        logic [7:0] sh;
        logic rd;
        logic nack;
        logic scl;
        logic pull; // data line pulled low
        logic done;
        logic ack_ok;
        logic [7:0] rdata;
        logic sync1; // first stage, read only by sync2
        logic sync2;
    } sml_eng_state_t;
    localparam sml_eng_state_t ENG_RESET = '{st: E_IDLE, scl: 1'b1, sync1: 1'b1,
        sync2: 1'b1, default: '0};
    sml_eng_state_t r;
    sml_eng_state_t next_r;
    logic tick;
    // ==========================================================
    // next state
    always_comb
    begin
        next_r = r;
        next_r.done = 1'b0;
        next_r.sync1 = sda_in;
        next_r.sync2 = r.sync1;
        tick = (r.qcnt == 8'(QTR - 1));
        if (r.st == E_IDLE)
        begin
            next_r.qcnt = 8'h00;
            next_r.qtr = 2'h0;
            next_r.bitn = 4'h0;
            if (bus.cmd_valid)
            begin
                next_r.rd = (bus.cmd == C_READ);
                next_r.nack = bus.send_nack;
                next_r.sh = bus.wdata;
                case (bus.cmd)
                    C_START: next_r.st = E_START; // data released, clock as is
                    C_STOP:
                    begin
                        next_r.st = E_STOP;
                        next_r.pull = 1'b1;
                    end
                    C_WRITE:
                    begin
                        next_r.st = E_BYTE;
                        next_r.pull = ~bus.wdata[7];
                    end
                    default:
                    begin
                        next_r.st = E_BYTE;
                        next_r.pull = 1'b0;
                    end
                endcase
                if (bus.cmd == C_START)
                    next_r.pull = 1'b0;
            end
        end
        else if (!tick)
            next_r.qcnt = r.qcnt + 8'h01;
        else
        begin
            next_r.qcnt = 8'h00;
            next_r.qtr = r.qtr + 2'h1;
            case (r.qtr)
                2'h0: next_r.scl = 1'b1;
                2'h1:
                begin
                    // data may only move while clock high for start and stop
                    if (r.st == E_START)
                        next_r.pull = 1'b1;
                    if (r.st == E_STOP)
                        next_r.pull = 1'b0;
                    if (r.st == E_BYTE && r.rd && r.bitn != `SML_ACK_BIT)
                        next_r.sh = {r.sh[6:0], r.sync2};
                    if (r.st == E_BYTE && !r.rd && r.bitn == `SML_ACK_BIT)
                        next_r.ack_ok = ~r.sync2;
                end
                2'h2: if (r.st != E_STOP) next_r.scl = 1'b0;
                default:
                begin
                    if (r.st != E_BYTE || r.bitn == `SML_ACK_BIT)
                    begin
                        next_r.st = E_IDLE;
                        next_r.done = 1'b1;
                        next_r.rdata = r.sh;
                    end
                    else
                    begin
                        next_r.bitn = r.bitn + 4'h1;
                        next_r.sh = r.rd ? r.sh : {r.sh[6:0], 1'b0};
                        // ack slot: writer releases, reader answers
                        if (r.bitn == 4'h7)
                            next_r.pull = r.rd ? ~r.nack : 1'b0;
                        else
                            next_r.pull = r.rd ? 1'b0 : ~r.sh[6];
                    end
                end
            endcase
        end
    end
    // ==========================================================
    // registers, frozen while ce is low
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            r <= ENG_RESET;
        else if (ce)
            r <= next_r;
    end
    assign scl_out = r.scl;
    assign sda_out = 1'b0; // open drain: only ever pulls low
    assign sda_oe = r.pull;
    assign bus.done = r.done;
    assign bus.ack_ok = r.ack_ok;
    assign bus.rdata = r.rdata;
    // ==========================================================
    // checks
    a_start_edge: assert property (@(posedge pclk) disable iff (!presetn)
        r.scl && $rose(r.pull) |-> r.st == E_START)
        else $error("data fell under high clock outside start");
    a_stop_edge: assert property (@(posedge pclk) disable iff (!presetn)
        r.scl && $fell(r.pull) |-> r.st == E_STOP)
        else $error("data rose under high clock outside stop");
endmodule // sml_wire_engine
